// File: src/mpu_top.sv
// measurement post-process unit: peak hold, averaging, scaling limits, efficiency and loss
`timescale 1ns/100ps
// Summary of operation
// - peak hold outputs largest value since clear
// - waveform and integration items pass live
// - peak compares averaged values when averaging
// - peak hold and display hold exclusive
// - signed items compared by magnitude
// - clear on key, interval end, sync
// - peak data refreshed every 50 ms update
// - held values drive analog out and saves
// - autosave captures values just before update
// - peak hold indicator while active
// - peak hold off after power recovery
// - rms or mean per system for S/Q/PF
// - ratios off or 0.01..9999.99, product limited
// - scaling and averaging indicators
// - average all items except 6 and 7, averaged saved
// - exponential filter stepped per 50 ms update
// - harmonic components averaged like other items
// - derived figures come from unaveraged input data
// - five response speeds plus off
// - float operands, higher power range applies
// - efficiency recomputed on each update that finds the divider idle, latest data
// - three pairs, 100*|out/in| and |in|-|out|
module mpu_top import mpu_pkg::*; #(
  parameter int UPD_CYCLES = UPDATE_CYCLES
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // acquisition pipeline
  input wire logic update_stb,
  input wire logic [NUM_ITEMS-1:0][DATA_W-1:0] meas_raw,
  input wire logic [NUM_SYS-1:0][DATA_W-1:0] u_rms,
  input wire logic [NUM_SYS-1:0][DATA_W-1:0] u_mean,
  input wire logic [NUM_SYS-1:0][DATA_W-1:0] i_rms,
  input wire logic [NUM_SYS-1:0][DATA_W-1:0] i_mean,
  input wire logic [NUM_PAIRS-1:0][DATA_W-1:0] p_in,
  input wire logic [NUM_PAIRS-1:0][DATA_W-1:0] p_out,
  input wire logic [NUM_PAIRS-1:0][RANGE_W-1:0] range_in,
  input wire logic [NUM_PAIRS-1:0][RANGE_W-1:0] range_out,
  // clear events
  input wire logic hold_key_stb,
  input wire logic interval_end_stb,
  input wire logic ext_sync_stb,
  // measurement outputs
  output logic [NUM_ITEMS-1:0][DATA_W-1:0] meas_out,
  output logic [NUM_ITEMS-1:0][DATA_W-1:0] save_data,
  output logic save_stb,
  output logic [NUM_SYS-1:0][DATA_W-1:0] u_calc,
  output logic [NUM_SYS-1:0][DATA_W-1:0] i_calc,
  // efficiency and loss
  output logic [NUM_PAIRS-1:0][DATA_W-1:0] eff_out,
  output logic [NUM_PAIRS-1:0][DATA_W-1:0] loss_out,
  output logic [NUM_PAIRS-1:0][RANGE_W-1:0] eff_range,
  output logic eff_done,
  // indicators
  output logic peak_hold_ind,
  output logic disp_hold_ind,
  output logic averaging_indicator,
  output logic scaling_ind,
  output logic [RATIO_W-1:0] voltage_transformer_ratio,
  output logic [RATIO_W-1:0] current_transformer_ratio
);

  function automatic logic ratio_ok(input logic [DATA_W-1:0] nv, input logic [RATIO_W-1:0] other);
    logic [RATIO_W-1:0] a;
    logic [RATIO_W-1:0] b;
    logic [2*RATIO_W-1:0] prod;
    a = (nv[RATIO_W-1:0] == '0) ? RATIO_UNITY : nv[RATIO_W-1:0];
    b = (other == '0) ? RATIO_UNITY : other;
    prod = {{RATIO_W{1'b0}}, a} * {{RATIO_W{1'b0}}, b};
    ratio_ok = (nv[DATA_W-1:RATIO_W] == '0) && (nv[RATIO_W-1:0] <= RATIO_MAX) && (prod <= RATIO_PROD_MAX);
  endfunction : ratio_ok

  function automatic logic [DATA_W-1:0] loss_calc(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    logic [FP_EXP_MSB:0] big;
    logic [FP_EXP_MSB:0] sml;
    logic sgn;
    logic [FP_MAN_W:0] mb;
    logic [FP_MAN_W:0] ms;
    logic [FP_MAN_W:0] df;
    logic [7:0] sh;
    logic [4:0] lz;
    logic found;
    logic signed [9:0] e;
    sgn = a[FP_EXP_MSB:0] < b[FP_EXP_MSB:0];
    big = sgn ? b[FP_EXP_MSB:0] : a[FP_EXP_MSB:0];
    sml = sgn ? a[FP_EXP_MSB:0] : b[FP_EXP_MSB:0];
    mb = {big[FP_EXP_MSB:FP_MAN_W] != '0, big[FP_MAN_W-1:0]};
    ms = {sml[FP_EXP_MSB:FP_MAN_W] != '0, sml[FP_MAN_W-1:0]};
    sh = big[FP_EXP_MSB:FP_MAN_W] - sml[FP_EXP_MSB:FP_MAN_W];
    ms = ms >> sh;
    df = mb - ms;
    lz = '0;
    found = 1'b0;
    for (int k = FP_MAN_W; k >= 0; k--) begin
      if (!found && !df[k]) begin
        lz = lz + 5'h1;
      end else begin
        found = 1'b1;
      end
    end
    e = 10'(big[FP_EXP_MSB:FP_MAN_W]) - 10'(lz);
    df = df << lz;
    if (!found || e <= 0) begin
      loss_calc = '0;
    end else begin
      loss_calc = {sgn, e[7:0], df[FP_MAN_W-1:0]};
    end
  endfunction : loss_calc

  function automatic logic [DATA_W-1:0] eff_pack(input logic [DATA_W-1:0] pi, input logic [DATA_W-1:0] po,
                                                 input logic [FP_MAN_W+1:0] q);
    logic signed [9:0] e;
    logic [FP_MAN_W:0] m;
    logic [FP_MAN_W+6:0] pr;
    logic [FP_MAN_W+1:0] sh;
    logic [FP_MAN_W-1:0] mant;
    e = 10'(po[FP_EXP_MSB:FP_MAN_W]) - 10'(pi[FP_EXP_MSB:FP_MAN_W]) + 10'(FP_BIAS + FP_HUNDRED_EXP);
    if (q[FP_MAN_W+1]) begin
      m = q[FP_MAN_W+1:1];
    end else begin
      m = q[FP_MAN_W:0];
      e = e - 10'sh1;
    end
    pr = 30'(m) * 30'(FP_HUNDRED_MUL);
    sh = pr[FP_MAN_W+1+FP_MUL_SHIFT:FP_MUL_SHIFT];
    if (sh[FP_MAN_W+1]) begin
      mant = sh[FP_MAN_W:1];
      e = e + 10'sh1;
    end else begin
      mant = sh[FP_MAN_W-1:0];
    end
    if (pi[FP_EXP_MSB:FP_MAN_W] == '0 || po[FP_EXP_MSB:FP_MAN_W] == '0 || e <= 0) begin
      eff_pack = '0;
    end else if (e >= FP_EXP_TOP) begin
      eff_pack = {1'b0, 8'hff, {FP_MAN_W{1'b0}}};
    end else begin
      eff_pack = {1'b0, e[7:0], mant};
    end
  endfunction : eff_pack

  // bus handshake
  logic wait_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic wr_acc;
  logic rd_load;
  logic upd;
  assign wr_acc = ce && avs_write && !wait_ff;
  assign rd_load = ce && avs_read && wait_ff;
  assign upd = ce && update_stb;
  assign avs_waitrequest = wait_ff;
  assign avs_readdata = rdata_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wait_ff <= 1'b1;
    end else if (ce) begin
      wait_ff <= !((avs_read || avs_write) && wait_ff);
    end
  end

  // control and ratio registers
  logic peak_en_ff;
  logic dhold_ff;
  logic asave_ff;
  mpu_speed_e speed_ff;
  logic [NUM_SYS-1:0] rect_mean_ff;
  logic [RATIO_W-1:0] vt_ff;
  logic [RATIO_W-1:0] ct_ff;
  logic reject_ff;
  logic late_ff;
  logic [LATE_W-1:0] late_cnt_ff;
  logic wr_ctrl;
  logic peak_start;
  logic vt_ok;
  logic ct_ok;
  logic reject_ev;
  logic [CTRL_SPD_MSB-CTRL_SPD_LSB:0] spd_wr;
  assign wr_ctrl = wr_acc && avs_address == REG_CTRL;
  assign peak_start = wr_ctrl && avs_writedata[CTRL_PEAK] && !peak_en_ff;
  assign vt_ok = ratio_ok(avs_writedata, ct_ff);
  assign ct_ok = ratio_ok(avs_writedata, vt_ff);
  assign reject_ev = wr_acc && ((avs_address == REG_VT && !vt_ok) || (avs_address == REG_CT && !ct_ok));
  assign spd_wr = avs_writedata[CTRL_SPD_MSB:CTRL_SPD_LSB];

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      peak_en_ff <= 1'b0;
      dhold_ff <= 1'b0;
      asave_ff <= 1'b0;
      speed_ff <= RESP_OFF;
      rect_mean_ff <= '0;
    end else if (wr_ctrl) begin
      peak_en_ff <= avs_writedata[CTRL_PEAK];
      dhold_ff <= avs_writedata[CTRL_DHOLD] && !avs_writedata[CTRL_PEAK];
      asave_ff <= avs_writedata[CTRL_ASAVE];
      rect_mean_ff <= avs_writedata[CTRL_RECT_LSB +: NUM_SYS];
      if (spd_wr <= SLOWEST_RESPONSE) begin
        speed_ff <= mpu_speed_e'(spd_wr);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vt_ff <= '0;
      ct_ff <= '0;
    end else if (wr_acc && avs_address == REG_VT && vt_ok) begin
      vt_ff <= avs_writedata[RATIO_W-1:0];
    end else if (wr_acc && avs_address == REG_CT && ct_ok) begin
      ct_ff <= avs_writedata[RATIO_W-1:0];
    end
  end

  // sticky status, set wins over clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reject_ff <= 1'b0;
      late_ff <= 1'b0;
    end else if (ce) begin
      if (reject_ev) begin
        reject_ff <= 1'b1;
      end else if (wr_acc && avs_address == REG_STAT && avs_writedata[STAT_REJECT]) begin
        reject_ff <= 1'b0;
      end
      if (late_cnt_ff == LATE_W'(2 * UPD_CYCLES)) begin
        late_ff <= 1'b1;
      end else if (wr_acc && avs_address == REG_STAT && avs_writedata[STAT_LATE]) begin
        late_ff <= 1'b0;
      end
    end
  end

  // watch for the 50 ms refresh
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      late_cnt_ff <= '0;
    end else if (upd) begin
      late_cnt_ff <= '0;
    end else if (ce && late_cnt_ff != LATE_W'(2 * UPD_CYCLES)) begin
      late_cnt_ff <= late_cnt_ff + LATE_W'(1);
    end
  end

  // indicators
  logic avg_ind_ff;
  logic scale_ind_ff;
  assign peak_hold_ind = peak_en_ff;
  assign disp_hold_ind = dhold_ff;
  assign averaging_indicator = avg_ind_ff;
  assign scaling_ind = scale_ind_ff;
  assign voltage_transformer_ratio = vt_ff;
  assign current_transformer_ratio = ct_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avg_ind_ff <= 1'b0;
      scale_ind_ff <= 1'b0;
    end else if (ce) begin
      avg_ind_ff <= speed_ff != RESP_OFF;
      scale_ind_ff <= vt_ff != '0 || ct_ff != '0;
    end
  end

  // peak clear events
  logic clr_pend_ff;
  logic clr_ev;
  logic clr_now;
  assign clr_ev = ce && ((hold_key_stb && peak_en_ff) || interval_end_stb || ext_sync_stb || peak_start);
  // an event on an update edge waits for the next update
  assign clr_now = clr_pend_ff;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clr_pend_ff <= 1'b0;
    end else if (clr_ev) begin
      clr_pend_ff <= 1'b1;
    end else if (upd) begin
      clr_pend_ff <= 1'b0;
    end
  end

  // averaging step
  logic [3:0] avg_shift;
  always_comb begin
    unique case (speed_ff)
      FAST_RESPONSE: avg_shift = SHIFT_FAST;
      MID_RESPONSE: avg_shift = SHIFT_MID;
      SLOW_RESPONSE: avg_shift = SHIFT_SLOW;
      SLOWER_RESPONSE: avg_shift = SHIFT_SLOWER;
      SLOWEST_RESPONSE: avg_shift = SHIFT_SLOWEST;
      default: avg_shift = '0;
    endcase
  end

  // per-item averaging, peak tracking, outputs
  logic signed [DATA_W-1:0] avg_ff [NUM_ITEMS];
  logic signed [DATA_W-1:0] peak_ff [NUM_ITEMS];
  logic [DATA_W-1:0] out_ff [NUM_ITEMS];
  logic [DATA_W-1:0] save_ff [NUM_ITEMS];
  logic save_stb_ff;
  assign save_stb = save_stb_ff;

  for (genvar i = 0; i < NUM_ITEMS; i++) begin : gen_item
    logic signed [DATA_W-1:0] raw;
    logic signed [DATA_W:0] diff;
    logic signed [DATA_W-1:0] src;
    logic signed [DATA_W-1:0] nxt_peak;
    logic [DATA_W-1:0] mag_src;
    logic [DATA_W-1:0] mag_peak;
    assign raw = meas_raw[i];
    assign meas_out[i] = out_ff[i];
    assign save_data[i] = save_ff[i];
    always_comb begin
      diff = {raw[DATA_W-1], raw} - {avg_ff[i][DATA_W-1], avg_ff[i]};
      if (speed_ff == RESP_OFF || BYPASS_MASK[i]) begin
        src = raw;
      end else begin
        src = avg_ff[i] + DATA_W'(diff >>> avg_shift);
      end
      mag_src = (SIGNED_MASK[i] && src[DATA_W-1]) ? DATA_W'(-src) : src;
      mag_peak = (SIGNED_MASK[i] && peak_ff[i][DATA_W-1]) ? DATA_W'(-peak_ff[i]) : peak_ff[i];
      if (!peak_en_ff || clr_now) begin
        nxt_peak = src;
      end else if (mag_src > mag_peak) begin
        nxt_peak = src;
      end else begin
        nxt_peak = peak_ff[i];
      end
    end
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        avg_ff[i] <= '0;
        peak_ff[i] <= '0;
      end else if (upd) begin
        avg_ff[i] <= src;
        peak_ff[i] <= nxt_peak;
      end
    end
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        out_ff[i] <= '0;
      end else if (upd && (!dhold_ff || BYPASS_MASK[i])) begin
        out_ff[i] <= BYPASS_MASK[i] ? raw : (peak_en_ff ? nxt_peak : src);
      end
    end
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        save_ff[i] <= '0;
      end else if (upd && asave_ff) begin
        save_ff[i] <= out_ff[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      save_stb_ff <= 1'b0;
    end else if (ce) begin
      save_stb_ff <= upd && asave_ff;
    end
  end

  // rectifier choice per phase system
  logic [DATA_W-1:0] u_calc_ff [NUM_SYS];
  logic [DATA_W-1:0] i_calc_ff [NUM_SYS];
  for (genvar s = 0; s < NUM_SYS; s++) begin : gen_sys
    assign u_calc[s] = u_calc_ff[s];
    assign i_calc[s] = i_calc_ff[s];
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        u_calc_ff[s] <= '0;
        i_calc_ff[s] <= '0;
      end else if (upd) begin
        u_calc_ff[s] <= rect_mean_ff[s] ? u_mean[s] : u_rms[s];
        i_calc_ff[s] <= rect_mean_ff[s] ? i_mean[s] : i_rms[s];
      end
    end
  end

  // loss and range per pair
  logic [DATA_W-1:0] loss_ff [NUM_PAIRS];
  logic [RANGE_W-1:0] range_ff [NUM_PAIRS];
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : gen_pair
    assign loss_out[p] = loss_ff[p];
    assign eff_range[p] = range_ff[p];
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        loss_ff[p] <= '0;
        range_ff[p] <= '0;
      end else if (upd) begin
        loss_ff[p] <= loss_calc(p_in[p], p_out[p]);
        range_ff[p] <= (range_in[p] > range_out[p]) ? range_in[p] : range_out[p];
      end
    end
  end

  // efficiency divider, one pair at a time
  mpu_eng_e state_ff;
  logic [PAIR_W-1:0] pair_ff;
  logic [4:0] step_ff;
  logic [FP_MAN_W+1:0] rem_ff;
  logic [FP_MAN_W+1:0] quo_ff;
  logic [DATA_W-1:0] pin_ff [NUM_PAIRS];
  logic [DATA_W-1:0] pout_ff [NUM_PAIRS];
  logic [DATA_W-1:0] eff_ff [NUM_PAIRS];
  logic eng_done_ff;
  logic [FP_MAN_W+1:0] dv;
  logic q_bit;
  logic [FP_MAN_W+1:0] nxt_quo;
  assign eff_done = eng_done_ff;
  always_comb begin
    dv = {2'b01, pin_ff[pair_ff][FP_MAN_W-1:0]};
    q_bit = rem_ff >= dv;
    nxt_quo = {quo_ff[FP_MAN_W:0], q_bit};
  end
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : gen_eff
    assign eff_out[p] = eff_ff[p];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= E_IDLE;
      pair_ff <= '0;
      step_ff <= '0;
      rem_ff <= '0;
      quo_ff <= '0;
      eng_done_ff <= 1'b0;
      for (int p = 0; p < NUM_PAIRS; p++) begin
        pin_ff[p] <= '0;
        pout_ff[p] <= '0;
        eff_ff[p] <= '0;
      end
    end else if (ce) begin
      eng_done_ff <= 1'b0;
      unique case (state_ff)
        E_IDLE: begin
          if (upd) begin
            for (int p = 0; p < NUM_PAIRS; p++) begin
              pin_ff[p] <= p_in[p];
              pout_ff[p] <= p_out[p];
            end
            pair_ff <= '0;
            state_ff <= E_LOAD;
          end
        end
        E_LOAD: begin
          rem_ff <= {2'b01, pout_ff[pair_ff][FP_MAN_W-1:0]};
          quo_ff <= '0;
          step_ff <= '0;
          state_ff <= E_DIV;
        end
        E_DIV: begin
          rem_ff <= (q_bit ? rem_ff - dv : rem_ff) << 1;
          quo_ff <= nxt_quo;
          step_ff <= step_ff + 5'h1;
          if (step_ff == DIV_STEPS) begin
            eff_ff[pair_ff] <= eff_pack(pin_ff[pair_ff], pout_ff[pair_ff], nxt_quo);
            if (pair_ff == PAIR_W'(NUM_PAIRS - 1)) begin
              eng_done_ff <= 1'b1;
              state_ff <= E_IDLE;
            end else begin
              pair_ff <= pair_ff + PAIR_W'(1);
              state_ff <= E_LOAD;
            end
          end
        end
        default: state_ff <= E_IDLE;
      endcase
    end
  end

  // register read mux
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (rd_load) begin
      rdata_ff <= '0;
      unique case (avs_address)
        REG_CTRL: begin
          rdata_ff[CTRL_PEAK] <= peak_en_ff;
          rdata_ff[CTRL_DHOLD] <= dhold_ff;
          rdata_ff[CTRL_SPD_MSB:CTRL_SPD_LSB] <= speed_ff;
          rdata_ff[CTRL_ASAVE] <= asave_ff;
          rdata_ff[CTRL_RECT_LSB +: NUM_SYS] <= rect_mean_ff;
        end
        REG_VT: rdata_ff[RATIO_W-1:0] <= vt_ff;
        REG_CT: rdata_ff[RATIO_W-1:0] <= ct_ff;
        REG_STAT: begin
          rdata_ff[STAT_PEAK] <= peak_en_ff;
          rdata_ff[STAT_AVG] <= avg_ind_ff;
          rdata_ff[STAT_SCALE] <= scale_ind_ff;
          rdata_ff[STAT_REJECT] <= reject_ff;
          rdata_ff[STAT_BUSY] <= state_ff != E_IDLE;
          rdata_ff[STAT_LATE] <= late_ff;
        end
        default: rdata_ff <= '0;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [DATA_W-1:0] chk_mag;
  assign chk_mag = peak_ff[CHK_ITEM][DATA_W-1] ? DATA_W'(-peak_ff[CHK_ITEM]) : peak_ff[CHK_ITEM];

  a_hold_exclusive: assert property (!(peak_en_ff && dhold_ff)) else $error("peak and display hold both on");
  a_peak_no_drop: assert property (peak_en_ff && upd && !clr_now |=> chk_mag >= $past(chk_mag))
    else $error("held magnitude dropped");
  a_clear_reload: assert property (upd && clr_now |=> peak_ff[CHK_ITEM] == $past(gen_item[CHK_ITEM].src))
    else $error("clear did not load the next sample");
  a_bypass_live: assert property (upd |=> out_ff[NUM_ITEMS-1] == $past(meas_raw[NUM_ITEMS-1]))
    else $error("waveform item not live");
  a_wait_one_cycle: assert property (ce && (avs_read || avs_write) && wait_ff |=> !wait_ff ##1 wait_ff)
    else $error("waitrequest timing wrong");
  a_ratio_reject: assert property (wr_acc && avs_address == REG_VT && !vt_ok |=> vt_ff == $past(vt_ff) && reject_ff)
    else $error("bad ratio accepted");
  a_ratio_range: assert property (vt_ff <= RATIO_MAX && ct_ff <= RATIO_MAX) else $error("ratio out of range");
  a_save_snapshot: assert property (upd && asave_ff |=> save_stb_ff && save_ff[CHK_ITEM] == $past(out_ff[CHK_ITEM]))
    else $error("save did not capture prior output");
  a_eff_bounded: assert property (upd && state_ff == E_IDLE |-> ##[1:1000] eng_done_ff)
    else $error("efficiency not recomputed");
  a_avg_flag: assert property (ce |=> avg_ind_ff == $past(speed_ff != RESP_OFF))
    else $error("averaging indicator wrong");
  a_peak_reset_off: assert property (@(posedge core_clk) disable iff (1'b0) $past(!rst_n) |-> !peak_hold_ind)
    else $error("peak hold on after reset");
  c_peak_clear: cover property (peak_en_ff && upd && clr_pend_ff);
  c_ratio_reject: cover property (reject_ev);
  c_eff_done: cover property (eng_done_ff);
  c_autosave: cover property (save_stb_ff && peak_en_ff);
endmodule : mpu_top

// File: src/mpu_pkg.sv
// constants and types for the measurement post-process unit
package mpu_pkg;
  // data shape
  localparam int NUM_ITEMS = 8;
  localparam int NUM_SYS = 4;
  localparam int NUM_PAIRS = 3;
  localparam int DATA_W = 32;
  localparam int RANGE_W = 4;
  localparam int ADDR_W = 4;
  localparam int PAIR_W = 2;
  // items 6 and 7 carry waveform and integration data
  localparam logic [NUM_ITEMS-1:0] BYPASS_MASK = 8'hc0;
  localparam logic [NUM_ITEMS-1:0] SIGNED_MASK = 8'h3c;
  localparam int CHK_ITEM = 2;
  // register word addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_VT = 4'h1;
  localparam logic [ADDR_W-1:0] REG_CT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h3;
  // ctrl fields
  localparam int CTRL_PEAK = 0;
  localparam int CTRL_DHOLD = 1;
  localparam int CTRL_SPD_LSB = 2;
  localparam int CTRL_SPD_MSB = 4;
  localparam int CTRL_ASAVE = 5;
  localparam int CTRL_RECT_LSB = 8;
  // status fields
  localparam int STAT_PEAK = 0;
  localparam int STAT_AVG = 1;
  localparam int STAT_SCALE = 2;
  localparam int STAT_REJECT = 3;
  localparam int STAT_BUSY = 4;
  localparam int STAT_LATE = 5;
  // transformer ratios in hundredths, zero means off
  localparam int RATIO_W = 20;
  localparam logic [RATIO_W-1:0] RATIO_MAX = 20'hf423f;
  localparam logic [RATIO_W-1:0] RATIO_UNITY = 20'h00064;
  localparam logic [2*RATIO_W-1:0] RATIO_PROD_MAX = 40'h2540be400;
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam int UPDATE_MS = 50;
  localparam int UPDATE_CYCLES = (CLK_HZ / 1000) * UPDATE_MS;
  localparam int LATE_W = 22;
  localparam int SETTLE_FAST_MS = 200;
  localparam int SETTLE_MID_MS = 1000;
  localparam int SETTLE_SLOW_MS = 5000;
  localparam int SETTLE_SLOWER_MS = 25000;
  localparam int SETTLE_SLOWEST_MS = 100000;
  localparam logic [3:0] SHIFT_FAST = 4'($clog2(SETTLE_FAST_MS / UPDATE_MS) - 1);
  localparam logic [3:0] SHIFT_MID = 4'($clog2(SETTLE_MID_MS / UPDATE_MS) - 1);
  localparam logic [3:0] SHIFT_SLOW = 4'($clog2(SETTLE_SLOW_MS / UPDATE_MS) - 1);
  localparam logic [3:0] SHIFT_SLOWER = 4'($clog2(SETTLE_SLOWER_MS / UPDATE_MS) - 1);
  localparam logic [3:0] SHIFT_SLOWEST = 4'($clog2(SETTLE_SLOWEST_MS / UPDATE_MS) - 1);
  // single precision float fields
  localparam int FP_MAN_W = 23;
  localparam int FP_EXP_MSB = 30;
  localparam int FP_SIGN = 31;
  localparam int FP_BIAS = 127;
  localparam int FP_EXP_TOP = 255;
  localparam int FP_HUNDRED_EXP = 6;
  localparam int FP_HUNDRED_MUL = 25;
  localparam int FP_MUL_SHIFT = 4;
  localparam logic [4:0] DIV_STEPS = 5'h18;
  typedef enum logic [2:0] {
    RESP_OFF = 3'b000,
    FAST_RESPONSE = 3'b001,
    MID_RESPONSE = 3'b010,
    SLOW_RESPONSE = 3'b011,
    SLOWER_RESPONSE = 3'b100,
    SLOWEST_RESPONSE = 3'b101
  } mpu_speed_e;
  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_LOAD = 2'b01,
    E_DIV = 2'b10
  } mpu_eng_e;
endpackage : mpu_pkg

// File: bench/mpu_src.sv
// acquisition pipeline model: one update per request
`timescale 1ns/100ps
module mpu_src import mpu_pkg::*; (
  // request from the bench
  input wire logic core_clk,
  input wire logic go,
  input wire logic [DATA_W-1:0] v,
  // update stream
  output logic update_stb = 1'b0,
  output logic [NUM_ITEMS-1:0][DATA_W-1:0] meas_raw = '0,
  output logic [NUM_SYS-1:0][DATA_W-1:0] u_rms = '0,
  output logic [NUM_SYS-1:0][DATA_W-1:0] u_mean = '0,
  output logic [NUM_SYS-1:0][DATA_W-1:0] i_rms = '0,
  output logic [NUM_SYS-1:0][DATA_W-1:0] i_mean = '0,
  output logic [NUM_PAIRS-1:0][DATA_W-1:0] p_in = '0,
  output logic [NUM_PAIRS-1:0][DATA_W-1:0] p_out = '0,
  output logic [NUM_PAIRS-1:0][RANGE_W-1:0] range_in = '0,
  output logic [NUM_PAIRS-1:0][RANGE_W-1:0] range_out = '0
);
  always @(posedge core_clk) begin
    update_stb <= go;
    meas_raw <= {NUM_ITEMS{v}};
    u_rms <= {NUM_SYS{v}};
    u_mean <= {NUM_SYS{~v}};
    i_rms <= {NUM_SYS{v}};
    i_mean <= {NUM_SYS{~v}};
    p_in <= {NUM_PAIRS{9'h081, v[22:0]}};
    p_out <= {NUM_PAIRS{9'h081, v[22:0]}};
    range_in <= {NUM_PAIRS{v[3:0]}};
    range_out <= {NUM_PAIRS{v[7:4]}};
  end
endmodule : mpu_src

// File: bench/mpu_top_tb.sv
// self-checking bench for the measurement post-process unit
`timescale 1ns/100ps
module mpu_top_tb import mpu_pkg::*;;
  logic core_clk = 0, rst_n = 0, go = 0, rd = 0, wr = 0, sync = 0, upd, wq, phi, dhi, avi, sci;
  logic hk = 0, ie = 0, sst, ed;
  logic [ADDR_W-1:0] adr = '0;
  logic [DATA_W-1:0] wd = '0, v = '0, rdv, rq;
  logic [RATIO_W-1:0] vtr, ctr;
  logic [NUM_ITEMS-1:0][DATA_W-1:0] raw, mo, sd;
  logic [NUM_SYS-1:0][DATA_W-1:0] ur, um, ir, im, uc, ic;
  logic [NUM_PAIRS-1:0][DATA_W-1:0] pi, po, eo, lo;
  logic [NUM_PAIRS-1:0][RANGE_W-1:0] ri, ro, er;
  int n_errors = 0, checks = 0, x, m, a, n_save = 0, n_done = 0;
  mpu_src i_src (.core_clk, .go, .v, .update_stb(upd), .meas_raw(raw), .u_rms(ur), .u_mean(um), .i_rms(ir),
    .i_mean(im), .p_in(pi), .p_out(po), .range_in(ri), .range_out(ro));
  mpu_top #(.UPD_CYCLES(50)) i_dut (.core_clk, .rst_n, .ce(1'b1), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rq), .avs_waitrequest(wq), .update_stb(upd),
    .meas_raw(raw), .u_rms(ur), .u_mean(um), .i_rms(ir), .i_mean(im), .p_in(pi), .p_out(po), .range_in(ri),
    .range_out(ro), .hold_key_stb(hk), .interval_end_stb(ie), .ext_sync_stb(sync), .meas_out(mo),
    .save_data(sd), .save_stb(sst), .u_calc(uc), .i_calc(ic), .eff_out(eo), .loss_out(lo), .eff_range(er),
    .eff_done(ed),
    .peak_hold_ind(phi), .disp_hold_ind(dhi), .averaging_indicator(avi), .scaling_ind(sci),
    .voltage_transformer_ratio(vtr), .current_transformer_ratio(ctr));
  initial forever #25 core_clk = ~core_clk;
  // pulse counters for save and efficiency strobes
  always @(posedge core_clk) begin
    n_save += int'(sst === 1'b1);
    n_done += int'(ed === 1'b1);
  end
  task automatic cyc(int n); repeat (n) @(posedge core_clk); endtask : cyc
  task automatic wrap_up(int bad);
    if (n_errors + bad == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task automatic chk(string s, logic [DATA_W-1:0] e, logic [DATA_W-1:0] g);
    checks++;
    n_errors += int'(g !== e);
    if (g !== e) $display("unexpected %s exp %h got %h", s, e, g);
  endtask : chk
  // avalon request held until waitrequest is sampled low
  task automatic bus(logic w, logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    int t = 0;
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    do @(posedge core_clk); while (wq !== 1'b0 && ++t < 99);
    if (t == 99) wrap_up(1);
    rdv = rq;
    wr <= 1'b0;
    rd <= 1'b0;
    cyc(1);
  endtask : bus
  // one update, clear pulses {interval end, hold key, sync} ahead of it
  task automatic upd_with(int y, logic [2:0] s);
    v <= y;
    go <= 1'b1;
    {ie, hk, sync} <= s;
    cyc(1);
    go <= 1'b0;
    {ie, hk, sync} <= 3'h0;
    cyc(82);
  endtask : upd_with
  initial begin
    void'($urandom(83));
    cyc(10);
    rst_n <= 1'b1;
    bus(1, REG_CTRL, 32'h3);
    for (int k = 0; k < 12; k++) begin
      x = int'($urandom_range(2000)) - 1000;
      if (k == 0 || k == 4 || k == 6 || k == 9 || (x < 0 ? -x : x) > (m < 0 ? -m : m)) m = x;
      upd_with(x, {k == 9, k == 4, k == 6});
      chk("peak", m, mo[CHK_ITEM]);
      chk("live", x, mo[6]);
      chk("rng", x[3:0] > x[7:4] ? x[3:0] : x[7:4], er[0]);
      chk("eff", 32'h42c80000, eo[0]);
      chk("loss", 0, lo[NUM_PAIRS-1]);
    end
    chk("done", 12, n_done);
    chk("pind", 1, phi);
    chk("dind", 0, dhi);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    chk("pind", 0, phi);
    bus(1, REG_CTRL, 32'h125);
    bus(1, REG_CT, 32'h4e20);
    bus(1, REG_VT, 32'hf423f);
    bus(0, REG_STAT, 0);
    chk("rej", 1, rdv[STAT_REJECT]);
    chk("vt", 0, vtr);
    chk("ct", 32'h4e20, ctr);
    chk("scl", 1, sci);
    chk("avg", 1, avi);
    bus(0, 4'h9, 0);
    chk("unmap", 0, rdv);
    a = 0;
    m = 0;
    for (int k = 0; k < 4; k++) begin
      x = int'($urandom_range(2000)) - 1000;
      upd_with(x, 3'h0);
      chk("save", m, sd[CHK_ITEM]);
      a = a + ((x - a) >>> SHIFT_FAST);
      if (k == 0 || (a < 0 ? -a : a) > (m < 0 ? -m : m)) m = a;
      chk("avgpeak", m, mo[CHK_ITEM]);
      chk("umean", ~x, uc[0]);
      chk("urms", x, uc[1]);
      chk("irms", x, ic[NUM_SYS-1]);
    end
    chk("saves", 4, n_save);
    chk("done", 16, n_done);
    wrap_up(0);
  end
endmodule : mpu_top_tb
